/* design/pmr_pkg.sv */
// Package for the misc interrupt and buck one register bank.
// Shared by the bank and its pin synchroniser; no surroundings assumed.
package pmr_pkg;

  // Register byte offsets on the control interface
  localparam logic [7:0] PMR_OFS_STATUS  = 8'h28;
  localparam logic [7:0] PMR_OFS_MASK    = 8'h29;
  localparam logic [7:0] PMR_OFS_SENSE   = 8'h2A;
  localparam logic [7:0] PMR_OFS_COIN    = 8'h30;
  localparam logic [7:0] PMR_OFS_RUN     = 8'h32;
  localparam logic [7:0] PMR_OFS_STBY    = 8'h33;
  localparam logic [7:0] PMR_OFS_SLP     = 8'h34;

  // Event bit positions, shared by status, mask and sense
  localparam int PMR_BIT_WAKE   = 0;
  localparam int PMR_BIT_SLEEP  = 1;
  localparam int PMR_BIT_BUTTON = 2;
  localparam int PMR_BIT_LOW    = 3;
  localparam int PMR_BIT_OVER   = 4;
  localparam int PMR_EVT_W      = 5;

  // Coin-cell control fields
  localparam int PMR_COIN_CODE_LSB = 0;
  localparam int PMR_COIN_CODE_W   = 4;
  localparam int PMR_COIN_EN_BIT   = 4;

  // Buck one voltage code width
  localparam int PMR_BUCK_CODE_W = 6;

  // Reset values
  localparam logic [4:0] PMR_RST_MASK    = 5'h1F;
  localparam logic [4:0] PMR_RST_STATUS  = 5'h00;
  localparam logic [3:0] PMR_RST_COIN    = 4'h0;
  localparam logic       PMR_RST_COIN_EN = 1'b0;

  // Control interface framing
  localparam logic [3:0] PMR_BYTE_BITS   = 4'h8;
  localparam logic [3:0] PMR_LAST_BIT    = 4'h7;

  // Live event levels, one bit per event
  typedef struct packed {
    logic supply_over_level;
    logic supply_low_level;
    logic button_level;
    logic sleep_in_progress;
    logic wake_in_progress;
  } pmr_sense_s;

  // Control interface receiver states
  typedef enum logic [3:0] {
    PMR_ST_IDLE,
    PMR_ST_ADDR,
    PMR_ST_ADDR_ACK,
    PMR_ST_REG,
    PMR_ST_REG_ACK,
    PMR_ST_WDATA,
    PMR_ST_WDATA_ACK,
    PMR_ST_RDATA,
    PMR_ST_RDATA_ACK
  } pmr_state_e;

endpackage : pmr_pkg

/* design/pmr_sync.sv */
// Three-flop synchroniser with agreement filter for pin inputs.
// Assumes asynchronous inputs; output changes once flops two and three agree.
`timescale 1ns/1ns
module pmr_sync
  import pmr_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         clk_sys_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] level_o
);

  logic [W-1:0] meta;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta   <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      meta   <= async_i;
      stage2 <= meta;
      stage3 <= stage2;
    end
  end

  // Take a bit only when the last two stages agree
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      level_o <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (stage2[i] == stage3[i]) begin
          level_o[i] <= stage3[i];
        end
      end
    end
  end

endmodule : pmr_sync

/* design/pmr_regs.sv */
// Misc interrupt and buck one register bank behind a two-wire control port.
// Assumes pins arrive asynchronously; fuse code is stable at reset release.
//
// Behaviour
// - Interrupt output low while any status bit is set and unmasked.
// - Mask bits: wake 0, sleep 1, button 2, low 3, over 4; 7..5 unused.
// - All five mask bits reset to one.
// - Masks are read/write and may also be set by device logic.
// - Sense bits 0 and 1 show transitions in progress; reset to zero.
// - Sense bit 2 follows the power button level.
// - Sense bit 3 is one while supply is below low warning.
// - Sense bit 4 is one while supply is above overvoltage.
// - Coin-cell voltage code bits 3..0 reset to zero.
// - Coin-cell charger enable at bit 4, reset zero.
// - Run code bits 5..0 loaded from fuses, then read/write.
// - Standby code six bits, fuse loaded, defaults to run code.
// - Sleep code six bits, fuse loaded, defaults to run code.
// - Status bits clear on write of one or on read.
`timescale 1ns/1ns
module pmr_regs
  import pmr_pkg::*;
#(
  // Bus address of the bank; value is arbitrary
  parameter logic [6:0] DEV_ADDR = 7'h08
) (
  input  wire logic                       clk_sys_i,
  input  wire logic                       rst_n_i,
  input  wire logic                       scl_i,
  input  wire logic                       sda_i,
  output logic                            sda_o,
  output logic                            sda_oe_o,
  input  wire pmr_sense_s                 sense_i,
  input  wire logic [PMR_EVT_W-1:0]       mask_set_i,
  input  wire logic [PMR_BUCK_CODE_W-1:0] fuse_run_code_i,
  output logic                            irq_out_n_o,
  output logic [PMR_COIN_CODE_W-1:0]      backup_cell_voltage_code_o,
  output logic                            backup_cell_charge_on_o,
  output logic [PMR_BUCK_CODE_W-1:0]      buck_one_run_code_o,
  output logic [PMR_BUCK_CODE_W-1:0]      buck_one_standby_code_o,
  output logic [PMR_BUCK_CODE_W-1:0]      buck_one_sleep_code_o
);

  // Synchronised pin levels
  logic [1:0]                 bus_lvl;
  logic                       scl;
  logic                       sda;
  pmr_sense_s                 sense;
  pmr_sense_s                 sense_q;

  // Register state
  logic [PMR_EVT_W-1:0]       status;
  logic [PMR_EVT_W-1:0]       mask;
  logic [PMR_EVT_W-1:0]       set_evt;
  logic [PMR_EVT_W-1:0]       next_status;
  logic [PMR_COIN_CODE_W-1:0] coin_code;
  logic                       coin_en;
  logic [PMR_BUCK_CODE_W-1:0] run_code;
  logic [PMR_BUCK_CODE_W-1:0] stby_code;
  logic [PMR_BUCK_CODE_W-1:0] slp_code;
  logic                       fuse_pending;
  logic                       irq_n;

  // Control port state
  pmr_state_e                 state;
  logic                       scl_q;
  logic                       sda_q;
  logic                       scl_rise;
  logic                       scl_fall;
  logic                       start_det;
  logic                       stop_det;
  logic [3:0]                 bit_cnt;
  logic [7:0]                 shreg;
  logic [7:0]                 tx;
  logic [7:0]                 reg_ptr;
  logic                       rw;
  logic                       master_nack;
  logic                       sda_drive;
  logic                       wr_en;
  logic [7:0]                 wr_addr;
  logic [7:0]                 wr_data;
  logic                       rd_clr;
  logic [PMR_EVT_W-1:0]       rd_clr_bits;
  logic [7:0]                 rd_data;

  // Pin synchronisers
  pmr_sync #(
    .W (2)
  ) u_sync_bus (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .async_i   ({scl_i, sda_i}),
    .level_o   (bus_lvl)
  );

  pmr_sync #(
    .W (PMR_EVT_W)
  ) u_sync_sense (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .async_i   (sense_i),
    .level_o   (sense)
  );

  assign scl = bus_lvl[1];
  assign sda = bus_lvl[0];

  // Bus edge and framing detection
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end

  assign scl_rise  = scl & ~scl_q;
  assign scl_fall  = ~scl & scl_q;
  assign start_det = scl & scl_q & sda_q & ~sda;
  assign stop_det  = scl & scl_q & ~sda_q & sda;

  // Read data mux
  always_comb begin
    rd_data = 8'h00;
    case (reg_ptr)
      PMR_OFS_STATUS: rd_data = {3'h0, status};
      PMR_OFS_MASK:   rd_data = {3'h0, mask};
      PMR_OFS_SENSE:  rd_data = {3'h0, sense};
      PMR_OFS_COIN:   rd_data = {3'h0, coin_en, coin_code};
      PMR_OFS_RUN:    rd_data = {2'h0, run_code};
      PMR_OFS_STBY:   rd_data = {2'h0, stby_code};
      PMR_OFS_SLP:    rd_data = {2'h0, slp_code};
      default:        rd_data = 8'h00;
    endcase
  end

  // Control port receiver and transmitter
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state       <= PMR_ST_IDLE;
      bit_cnt     <= 4'h0;
      shreg       <= 8'h00;
      tx          <= 8'h00;
      reg_ptr     <= 8'h00;
      rw          <= 1'b0;
      master_nack <= 1'b0;
      sda_drive   <= 1'b0;
      wr_en       <= 1'b0;
      wr_addr     <= 8'h00;
      wr_data     <= 8'h00;
      rd_clr      <= 1'b0;
      rd_clr_bits <= '0;
    end else begin
      wr_en  <= 1'b0;
      rd_clr <= 1'b0;
      if (start_det) begin
        state     <= PMR_ST_ADDR;
        bit_cnt   <= 4'h0;
        sda_drive <= 1'b0;
      end else if (stop_det) begin
        state     <= PMR_ST_IDLE;
        sda_drive <= 1'b0;
      end else if (scl_rise) begin
        case (state)
          PMR_ST_ADDR, PMR_ST_REG, PMR_ST_WDATA: begin
            shreg   <= {shreg[6:0], sda};
            bit_cnt <= bit_cnt + 4'h1;
          end
          PMR_ST_RDATA_ACK: begin
            master_nack <= sda;
          end
          default: begin
          end
        endcase
      end else if (scl_fall) begin
        case (state)
          PMR_ST_ADDR: begin
            if (bit_cnt == PMR_BYTE_BITS) begin
              if (shreg[7:1] == DEV_ADDR) begin
                rw        <= shreg[0];
                sda_drive <= 1'b1;
                state     <= PMR_ST_ADDR_ACK;
              end else begin
                state <= PMR_ST_IDLE;
              end
            end
          end
          PMR_ST_ADDR_ACK: begin
            bit_cnt <= 4'h0;
            if (rw) begin
              tx        <= rd_data;
              sda_drive <= ~rd_data[7];
              reg_ptr   <= reg_ptr + 8'h01;
              state     <= PMR_ST_RDATA;
              if (reg_ptr == PMR_OFS_STATUS) begin
                rd_clr      <= 1'b1;
                rd_clr_bits <= status;
              end
            end else begin
              sda_drive <= 1'b0;
              state     <= PMR_ST_REG;
            end
          end
          PMR_ST_REG: begin
            if (bit_cnt == PMR_BYTE_BITS) begin
              reg_ptr   <= shreg;
              sda_drive <= 1'b1;
              state     <= PMR_ST_REG_ACK;
            end
          end
          PMR_ST_REG_ACK, PMR_ST_WDATA_ACK: begin
            sda_drive <= 1'b0;
            bit_cnt   <= 4'h0;
            state     <= PMR_ST_WDATA;
          end
          PMR_ST_WDATA: begin
            if (bit_cnt == PMR_BYTE_BITS) begin
              wr_en     <= 1'b1;
              wr_addr   <= reg_ptr;
              wr_data   <= shreg;
              reg_ptr   <= reg_ptr + 8'h01;
              sda_drive <= 1'b1;
              state     <= PMR_ST_WDATA_ACK;
            end
          end
          PMR_ST_RDATA: begin
            if (bit_cnt == PMR_LAST_BIT) begin
              sda_drive <= 1'b0;
              state     <= PMR_ST_RDATA_ACK;
            end else begin
              tx        <= {tx[6:0], 1'b0};
              sda_drive <= ~tx[6];
              bit_cnt   <= bit_cnt + 4'h1;
            end
          end
          PMR_ST_RDATA_ACK: begin
            bit_cnt <= 4'h0;
            if (master_nack) begin
              sda_drive <= 1'b0;
              state     <= PMR_ST_IDLE;
            end else begin
              tx        <= rd_data;
              sda_drive <= ~rd_data[7];
              reg_ptr   <= reg_ptr + 8'h01;
              state     <= PMR_ST_RDATA;
              if (reg_ptr == PMR_OFS_STATUS) begin
                rd_clr      <= 1'b1;
                rd_clr_bits <= status;
              end
            end
          end
          default: begin
            state <= PMR_ST_IDLE;
          end
        endcase
      end
    end
  end

  // Open-drain data pin only ever pulls low
  assign sda_o    = 1'b0;
  assign sda_oe_o = sda_drive;

  // Event detection from synchronised levels
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sense_q <= '0;
    end else begin
      sense_q <= sense;
    end
  end

  // Transition done on falling in-progress; button any change
  always_comb begin
    set_evt                 = '0;
    set_evt[PMR_BIT_WAKE]   = sense_q.wake_in_progress &
                              ~sense.wake_in_progress;
    set_evt[PMR_BIT_SLEEP]  = sense_q.sleep_in_progress &
                              ~sense.sleep_in_progress;
    set_evt[PMR_BIT_BUTTON] = sense_q.button_level ^ sense.button_level;
    set_evt[PMR_BIT_LOW]    = ~sense_q.supply_low_level &
                              sense.supply_low_level;
    set_evt[PMR_BIT_OVER]   = ~sense_q.supply_over_level &
                              sense.supply_over_level;
  end

  // Write one or read clears, set wins
  always_comb begin
    next_status = status;
    if (wr_en && (wr_addr == PMR_OFS_STATUS)) begin
      next_status = next_status & ~wr_data[PMR_EVT_W-1:0];
    end
    if (rd_clr) begin
      next_status = next_status & ~rd_clr_bits;
    end
    next_status = next_status | set_evt;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status <= PMR_RST_STATUS;
    end else begin
      status <= next_status;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mask <= PMR_RST_MASK;
    end else begin
      if (wr_en && (wr_addr == PMR_OFS_MASK)) begin
        mask <= wr_data[PMR_EVT_W-1:0] | mask_set_i;
      end else begin
        mask <= mask | mask_set_i;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      coin_code <= PMR_RST_COIN;
      coin_en   <= PMR_RST_COIN_EN;
    end else if (wr_en && (wr_addr == PMR_OFS_COIN)) begin
      coin_code <= wr_data[PMR_COIN_CODE_LSB +: PMR_COIN_CODE_W];
      coin_en   <= wr_data[PMR_COIN_EN_BIT];
    end
  end

  // Fuse code taken on the first edge after reset release
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fuse_pending <= 1'b1;
    end else begin
      fuse_pending <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_code <= '0;
    end else if (fuse_pending) begin
      run_code <= fuse_run_code_i;
    end else if (wr_en && (wr_addr == PMR_OFS_RUN)) begin
      run_code <= wr_data[PMR_BUCK_CODE_W-1:0];
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stby_code <= '0;
    end else if (fuse_pending) begin
      stby_code <= fuse_run_code_i;
    end else if (wr_en && (wr_addr == PMR_OFS_STBY)) begin
      stby_code <= wr_data[PMR_BUCK_CODE_W-1:0];
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      slp_code <= '0;
    end else if (fuse_pending) begin
      slp_code <= fuse_run_code_i;
    end else if (wr_en && (wr_addr == PMR_OFS_SLP)) begin
      slp_code <= wr_data[PMR_BUCK_CODE_W-1:0];
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_n <= 1'b1;
    end else begin
      irq_n <= ~|(status & ~mask);
    end
  end

  assign irq_out_n_o                = irq_n;
  assign backup_cell_voltage_code_o = coin_code;
  assign backup_cell_charge_on_o    = coin_en;
  assign buck_one_run_code_o        = run_code;
  assign buck_one_standby_code_o    = stby_code;
  assign buck_one_sleep_code_o      = slp_code;

endmodule : pmr_regs

/* verif/pmr_regs_checker.sv */
// Port checker for the misc interrupt and buck one register bank.
// Bound to pmr_regs; single clock, asynchronous active-low reset.
`timescale 1ns/1ns
module pmr_regs_checker
  import pmr_pkg::*;
(
  input wire logic                       clk_sys_i,
  input wire logic                       rst_n_i,
  input wire logic                       scl_i,
  input wire logic                       sda_oe_o,
  input wire logic [PMR_EVT_W-1:0]       mask_set_i,
  input wire logic [PMR_BUCK_CODE_W-1:0] fuse_run_code_i,
  input wire logic                       irq_out_n_o,
  input wire logic [PMR_COIN_CODE_W-1:0] backup_cell_voltage_code_o,
  input wire logic                       backup_cell_charge_on_o,
  input wire logic [PMR_BUCK_CODE_W-1:0] buck_one_run_code_o,
  input wire logic [PMR_BUCK_CODE_W-1:0] buck_one_standby_code_o,
  input wire logic [PMR_BUCK_CODE_W-1:0] buck_one_sleep_code_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  sequence mask_all_s;
    (mask_set_i == 5'h1F) [*2];
  endsequence
  sequence load_s;
    $rose(rst_n_i) ##1 1'b1;
  endsequence

  coin_reset_a: assert property (
    $rose(rst_n_i) |-> backup_cell_voltage_code_o == 4'h0
      && !backup_cell_charge_on_o)
    else $error("coin fields not zero after reset");
  irq_quiet_a: assert property (
    $rose(rst_n_i) |-> irq_out_n_o [*8])
    else $error("interrupt low while all masks set");
  buck_default_a: assert property (
    load_s |-> buck_one_run_code_o == fuse_run_code_i
      && buck_one_standby_code_o == fuse_run_code_i
      && buck_one_sleep_code_o == fuse_run_code_i)
    else $error("buck codes not loaded from fuse");
  mask_set_a: assert property (
    mask_all_s |=> irq_out_n_o)
    else $error("device mask set did not release interrupt");
  irq_cause_a: assert property (
    $fell(irq_out_n_o) |-> $past(mask_set_i, 2) != 5'h1F)
    else $error("interrupt fell while all masked");
  oe_timing_a: assert property (
    $changed(sda_oe_o) |-> !scl_i)
    else $error("data drive changed while bus clock high");
  coin_change_a: assert property (
    $changed({backup_cell_charge_on_o, backup_cell_voltage_code_o})
      |-> !scl_i)
    else $error("coin field changed outside a bus write");
  stby_change_a: assert property (
    $changed(buck_one_standby_code_o) && $past(rst_n_i, 2) |-> !scl_i)
    else $error("standby code changed outside a bus write");
endmodule : pmr_regs_checker

/* verif/pmr_host.sv */
// Host model: two-wire bus master for register access.
// Assumes a pulled-up data line resolved by the bench.
`timescale 1ns/1ns
module pmr_host
#(
  // Bus address of the bank; value is arbitrary
  parameter logic [6:0] DEV = 7'h08
) (
  input  wire logic clk_sys_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_pull_o
);
  initial begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end

  task automatic gap();
    repeat (25) @(negedge clk_sys_i);
  endtask : gap

  task automatic start_c();
    sda_pull_o = 1'b0;
    gap();
    scl_o = 1'b1;
    gap();
    sda_pull_o = 1'b1;
    gap();
    scl_o = 1'b0;
    gap();
  endtask : start_c

  task automatic stop_c();
    sda_pull_o = 1'b1;
    gap();
    scl_o = 1'b1;
    gap();
    sda_pull_o = 1'b0;
    gap();
  endtask : stop_c

  task automatic byte_x(input logic [7:0] d, output logic [8:0] r);
    logic [8:0] s;
    s = {d, 1'b1};
    for (int i = 8; i >= 0; i--) begin
      sda_pull_o = !s[i];
      gap();
      scl_o = 1'b1;
      gap();
      r[i] = sda_i;
      gap();
      scl_o = 1'b0;
      gap();
    end
  endtask : byte_x

  task automatic write_reg(input logic [7:0] ofs, input logic [7:0] d,
                           output logic ok);
    logic [8:0] a, b, c;
    start_c();
    byte_x({DEV, 1'b0}, a);
    byte_x(ofs, b);
    byte_x(d, c);
    stop_c();
    ok = !a[0] && !b[0] && !c[0];
  endtask : write_reg

  // status read clears; last byte ends with NACK
  task automatic read_reg(input logic [7:0] ofs, output logic [7:0] d);
    logic [8:0] a;
    start_c();
    byte_x({DEV, 1'b0}, a);
    byte_x(ofs, a);
    start_c();
    byte_x({DEV, 1'b1}, a);
    byte_x(8'hFF, a);
    stop_c();
    d = a[8:1];
  endtask : read_reg
endmodule : pmr_host

/* verif/test_pmic_misc_irq_and_buck1_regs.sv */
// Self-checking bench for the misc interrupt and buck one register bank.
// Host model drives the bus; bench drives sense, mask set and fuse pins.
`timescale 1ns/1ns
module test_pmic_misc_irq_and_buck1_regs
  import pmr_pkg::*;
;
  logic       clk_sys_i, rst_n_i, scl, pull, sda_oe, sda_drv, irq_n, charge;
  pmr_sense_s sense;
  logic [4:0] mask_set;
  logic [5:0] fuse, run, stby, slp;
  logic [3:0] coin;
  int         fail_count = 0;
  int         n_checks = 0;
  wire        sda = !pull && !(sda_oe && !sda_drv);

  pmr_regs #(.DEV_ADDR(7'h08)) DUT (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_drv), .sda_oe_o(sda_oe), .sense_i(sense),
    .mask_set_i(mask_set), .fuse_run_code_i(fuse), .irq_out_n_o(irq_n),
    .backup_cell_voltage_code_o(coin), .backup_cell_charge_on_o(charge),
    .buck_one_run_code_o(run), .buck_one_standby_code_o(stby),
    .buck_one_sleep_code_o(slp));
  pmr_host #(.DEV(7'h08)) host (.clk_sys_i(clk_sys_i), .sda_i(sda),
    .scl_o(scl), .sda_pull_o(pull));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out();
    if (fail_count == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out

  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    logic ok;
    host.write_reg(ofs, d, ok);
    check({7'h0, ok}, 8'h01);
  endtask : wr

  task automatic t_reset();
    logic [7:0] d;
    host.read_reg(PMR_OFS_MASK, d);
    check(d, 8'h1F);
    host.read_reg(PMR_OFS_COIN, d);
    check(d, 8'h00);
    host.read_reg(PMR_OFS_STBY, d);
    check(d, {2'b00, fuse});
    check({2'b00, run}, {2'b00, fuse});
    check({2'b00, slp}, {2'b00, fuse});
  endtask : t_reset

  task automatic t_sense();
    logic [7:0] d;
    for (int i = 0; i < 5; i++) begin
      sense = pmr_sense_s'(5'h01 << i);
      host.read_reg(PMR_OFS_SENSE, d);
      check(d, 8'h01 << i);
      check({7'h0, irq_n}, 8'h01);
    end
    sense = '0;
  endtask : t_sense

  task automatic t_irq();
    logic [7:0] d;
    wr(PMR_OFS_MASK, 8'h00);
    check({7'h0, irq_n}, 8'h00);
    host.read_reg(PMR_OFS_STATUS, d);
    check(d, 8'h1F);
    check({7'h0, irq_n}, 8'h01);
    sense.button_level = 1'b1;
    repeat (10) @(negedge clk_sys_i);
    check({7'h0, irq_n}, 8'h00);
    wr(PMR_OFS_STATUS, 8'h04);
    check({7'h0, irq_n}, 8'h01);
    mask_set = 5'h1F;
    repeat (3) @(negedge clk_sys_i);
    mask_set = 5'h00;
    host.read_reg(PMR_OFS_MASK, d);
    check(d, 8'h1F);
    wr(PMR_OFS_MASK, 8'hE4);
    host.read_reg(PMR_OFS_MASK, d);
    check(d, 8'h04);
  endtask : t_irq

  task automatic t_ctrl();
    logic [7:0] d;
    wr(PMR_OFS_COIN, 8'h1A);
    check({3'h0, charge, coin}, 8'h1A);
    host.read_reg(PMR_OFS_COIN, d);
    check(d, 8'h1A);
    wr(PMR_OFS_RUN, 8'h3F);
    check({2'b00, run}, 8'h3F);
    wr(PMR_OFS_STBY, 8'hC0);
    check({2'b00, stby}, 8'h00);
    wr(PMR_OFS_SLP, 8'h15);
    check({2'b00, slp}, 8'h15);
    host.read_reg(8'h31, d);
    check(d, 8'h00);
  endtask : t_ctrl

  task automatic t_rearm();
    fuse = 6'h2B;
    rst_n_i = 1'b0;
    repeat (12) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    check({3'h0, charge, coin}, 8'h00);
    check({2'b00, slp}, {2'b00, fuse});
    check({7'h0, irq_n}, 8'h01);
  endtask : t_rearm

  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  initial begin
    rst_n_i = 1'b0;
    sense = '0;
    mask_set = 5'h00;
    fuse = 6'h1C;
    repeat (12) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    t_reset();
    t_sense();
    t_irq();
    t_ctrl();
    t_rearm();
    close_out();
  end

  initial begin
    repeat (90000) @(posedge clk_sys_i);
    fail_count++;
    close_out();
  end
endmodule : test_pmic_misc_irq_and_buck1_regs

bind pmr_regs pmr_regs_checker u_chk (.clk_sys_i(clk_sys_i),
  .rst_n_i(rst_n_i), .scl_i(scl_i), .sda_oe_o(sda_oe_o),
  .mask_set_i(mask_set_i), .fuse_run_code_i(fuse_run_code_i),
  .irq_out_n_o(irq_out_n_o),
  .backup_cell_voltage_code_o(backup_cell_voltage_code_o),
  .backup_cell_charge_on_o(backup_cell_charge_on_o),
  .buck_one_run_code_o(buck_one_run_code_o),
  .buck_one_standby_code_o(buck_one_standby_code_o),
  .buck_one_sleep_code_o(buck_one_sleep_code_o));
